// ==== pkg/icrc_consts.svh ====
`ifndef ICRC_CONSTS_SVH
`define ICRC_CONSTS_SVH

// ----------------------------------------
// Register indexes, byte address is index times four
// ----------------------------------------
`define ICRC_IDX_TARGET   6'h0B
`define ICRC_IDX_UNLOCK   6'h0C
`define ICRC_IDX_STATUS   6'h0D
`define ICRC_ADDR_TARGET  ({`ICRC_IDX_TARGET, 2'h0})
`define ICRC_ADDR_UNLOCK  ({`ICRC_IDX_UNLOCK, 2'h0})
`define ICRC_ADDR_STATUS  ({`ICRC_IDX_STATUS, 2'h0})

// ----------------------------------------
// Reset values and keys
// ----------------------------------------
`define ICRC_TARGET_RST   8'h00
`define ICRC_UNLOCK_KEY   8'h93
`define ICRC_CRC_SEED     16'hFFFF
`define ICRC_STAT_MODE    0

// ----------------------------------------
// Link transfer kinds, low two bits of the address byte
// ----------------------------------------
`define ICRC_KIND_DATW    2'h0
`define ICRC_KIND_DATR    2'h1
`define ICRC_KIND_CMDW    2'h2
`define ICRC_KIND_CMDR    2'h3

// ----------------------------------------
// Command codes, upper five bits of the command byte
// ----------------------------------------
`define ICRC_CMD_PROGRAM  5'h14
`define ICRC_CMD_ERASE    5'h06
`define ICRC_CMD_BLANK    5'h0D
`define ICRC_CMD_CLRCRC   5'h1A
`define ICRC_CMD_RESET    5'h09

`endif

// ==== pkg/icrc_pkg.sv ====
`default_nettype none

package icrc_pkg;

	typedef enum logic [2:0] {
		LS_IDLE,
		LS_CMDW,
		LS_CMDR,
		LS_DATW,
		LS_DATR,
		LS_SKIP
	} icrc_lstate_t;

endpackage

`default_nettype wire

// ==== pkg/icrc_crc_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface icrc_crc_if;
	logic        seed;
	logic        fold;
	logic [7:0]  data;
	logic [15:0] crc;

	modport ctl (output seed, output fold, output data, input crc);
	modport eng (input seed, input fold, input data, output crc);
endinterface

`default_nettype wire

// ==== hw/icrc_crc16.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icrc_consts.svh"

module icrc_crc16 (
	// Link clock and reset
	input  wire logic lclk,
	input  wire logic lrst_n,
	// Checksum control
	icrc_crc_if.eng   crc_io
);

	// ----------------------------------------
	// Bit-serial fold, msb first
	// ----------------------------------------
	logic [15:0] crc_ff;
	wire  [15:0] stage [0:8];
	wire  [7:0]  feedback_bit;

	assign stage[0] = crc_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_bit
			wire incoming_bit;
			wire [15:0] cur;
			assign cur              = stage[gi];
			assign incoming_bit     = crc_io.data[7 - gi];
			assign feedback_bit[gi] = cur[15] ^ incoming_bit;
			assign stage[gi + 1]    = {cur[14] ^ feedback_bit[gi], cur[13:2],
				cur[1] ^ feedback_bit[gi], cur[0], feedback_bit[gi]};
		end
	endgenerate

	// ----------------------------------------
	// Checksum register
	// ----------------------------------------
	always_ff @(posedge lclk or negedge lrst_n) begin
		if (!lrst_n) begin
			crc_ff <= `ICRC_CRC_SEED;
		end else if (crc_io.seed) begin
			crc_ff <= `ICRC_CRC_SEED;
		end else if (crc_io.fold) begin
			crc_ff <= stage[8];
		end
	end

	assign crc_io.crc = crc_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	crc_vector_a: assert property (@(posedge lclk) disable iff (!lrst_n)
		crc_io.fold && !crc_io.seed && crc_io.data == 8'hF6 && crc_ff == 16'hFFFF
		|=> crc_ff == 16'hFF36)
		else $error("checksum fold of F6 from seed is wrong");

	crc_hold_a: assert property (@(posedge lclk) disable iff (!lrst_n)
		!crc_io.seed && !crc_io.fold |=> $stable(crc_ff))
		else $error("checksum changed without cause");

	crc_seed_a: assert property (@(posedge lclk) disable iff (!lrst_n)
		crc_io.seed |=> crc_ff == 16'hFFFF)
		else $error("checksum not seeded with all ones");

	crc_fold_c: cover property (@(posedge lclk) disable iff (!lrst_n)
		crc_io.fold ##2 crc_io.fold);

endmodule

`default_nettype wire

// ==== hw/icrc_top.sv ====
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "icrc_consts.svh"


module icrc_top (
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core side
	output logic             isp_mode,
	output logic             cpu_wake,
	// Link byte stream from the serial engine
	input  wire logic        lclk,
	input  wire logic        lk_frame_start,
	input  wire logic        lk_byte_valid,
	input  wire logic [7:0]  lk_byte,
	input  wire logic        lk_slave_ack,
	// Link answers
	output logic             lk_addressed,
	output logic      [7:0]  lk_tx_byte
);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic        pready_ff;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	logic [7:0]  isp_target_address_ff;
	logic        isp_mode_ff;
	logic        cpu_wake_ff;

	wire apb_access = psel && penable;
	wire apb_done   = apb_access && pready_ff;
	wire hit_target = paddr == `ICRC_ADDR_TARGET;
	wire hit_unlock = paddr == `ICRC_ADDR_UNLOCK;
	wire hit_status = paddr == `ICRC_ADDR_STATUS;
	wire apb_hit    = hit_target || hit_unlock || hit_status;
	wire wr_target  = apb_done && pwrite && hit_target;
	wire wr_unlock  = apb_done && pwrite && hit_unlock;
	wire key_ok     = pwdata[7:0] == `ICRC_UNLOCK_KEY;

	// Write-only registers read as zero
	wire [31:0] rd_mux = hit_status ?
		{31'h0000_0000, isp_mode_ff} : 32'h0000_0000;

	wire        nxt_pready  = apb_access && !pready_ff;
	wire [31:0] nxt_prdata  = (nxt_pready && !pwrite) ? rd_mux : 32'h0000_0000;
	wire        nxt_pslverr = nxt_pready && !apb_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			pready_ff  <= nxt_pready;
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ----------------------------------------
	// Wake event from link, toggle crossing
	// ----------------------------------------
	logic lk_wake_tgl_ff;
	logic wk_s1_ff;
	logic wk_s2_ff;
	logic wk_s3_ff;

	wire wake_edge = wk_s2_ff ^ wk_s3_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wk_s1_ff <= 1'b0;
			wk_s2_ff <= 1'b0;
			wk_s3_ff <= 1'b0;
		end else begin
			wk_s1_ff <= lk_wake_tgl_ff;
			wk_s2_ff <= wk_s1_ff;
			wk_s3_ff <= wk_s2_ff;
		end
	end

	// ----------------------------------------
	// Programming registers
	// ----------------------------------------
	// A fresh unlock write wins over a wake arriving in the same cycle
	wire nxt_isp_mode = wr_unlock ? key_ok :
		(wake_edge ? 1'b0 : isp_mode_ff);
	wire [7:0] nxt_target = wr_target ? pwdata[7:0] : isp_target_address_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isp_target_address_ff <= `ICRC_TARGET_RST;
			isp_mode_ff           <= 1'b0;
			cpu_wake_ff           <= 1'b0;
		end else begin
			isp_target_address_ff <= nxt_target;
			isp_mode_ff           <= nxt_isp_mode;
			cpu_wake_ff           <= wake_edge;
		end
	end

	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign isp_mode = isp_mode_ff;
	assign cpu_wake = cpu_wake_ff;

	// ----------------------------------------
	// Link reset and enable crossing
	// ----------------------------------------
	logic lrst_s1_ff;
	logic lrst_n_ff;
	logic en_s1_ff;
	logic en_s2_ff;
	logic [7:0] tgt_lk_ff;

	always_ff @(posedge lclk or negedge presetn) begin
		if (!presetn) begin
			lrst_s1_ff <= 1'b0;
			lrst_n_ff  <= 1'b0;
		end else begin
			lrst_s1_ff <= 1'b1;
			lrst_n_ff  <= lrst_s1_ff;
		end
	end

	// Address is sampled only while disabled; firmware sets it before unlocking
	always_ff @(posedge lclk or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			en_s1_ff  <= 1'b0;
			en_s2_ff  <= 1'b0;
			tgt_lk_ff <= `ICRC_TARGET_RST;
		end else begin
			en_s1_ff  <= isp_mode_ff;
			en_s2_ff  <= en_s1_ff;
			tgt_lk_ff <= en_s2_ff ? tgt_lk_ff : isp_target_address_ff;
		end
	end

	// ----------------------------------------
	// Link transfer decode
	// ----------------------------------------
	icrc_pkg::icrc_lstate_t lstate_ff;
	icrc_pkg::icrc_lstate_t nxt_kind;
	logic [2:0]  idx_ff;
	logic [7:0]  cmd_ff;
	logic [7:0]  page_ff;
	logic [6:0]  low_ff;
	logic        lk_addressed_ff;
	logic [7:0]  lk_tx_byte_ff;
	icrc_crc_if  crc_io ();

	wire lk_first  = lk_byte_valid && lstate_ff == icrc_pkg::LS_IDLE;
	wire lk_match  = en_s2_ff && lk_byte[7:2] == tgt_lk_ff[7:2];
	wire in_cmdw   = lk_byte_valid && lstate_ff == icrc_pkg::LS_CMDW;
	wire in_cmdr   = lk_byte_valid && lstate_ff == icrc_pkg::LS_CMDR;
	wire in_datw   = lk_byte_valid && lstate_ff == icrc_pkg::LS_DATW;
	wire cmdw_cmd  = in_cmdw && idx_ff == 3'h1 && lk_slave_ack;
	wire cmdw_page = in_cmdw && idx_ff == 3'h2 && lk_slave_ack;
	wire is_clr    = cmdw_cmd && lk_byte[7:3] == `ICRC_CMD_CLRCRC;
	wire is_rst    = cmdw_cmd && lk_byte[7:3] == `ICRC_CMD_RESET;
	wire datw_low  = in_datw && idx_ff == 3'h1;
	wire datw_data = in_datw && idx_ff >= 3'h2 && lk_slave_ack;
	wire is_prog   = cmd_ff[7:3] == `ICRC_CMD_PROGRAM;
	wire datr_data = lk_byte_valid && lstate_ff == icrc_pkg::LS_DATR && idx_ff >= 3'h1;

	always_comb begin
		case (lk_byte[1:0])
			`ICRC_KIND_CMDW: nxt_kind = icrc_pkg::LS_CMDW;
			`ICRC_KIND_CMDR: nxt_kind = icrc_pkg::LS_CMDR;
			`ICRC_KIND_DATW: nxt_kind = icrc_pkg::LS_DATW;
			`ICRC_KIND_DATR: nxt_kind = icrc_pkg::LS_DATR;
			default:         nxt_kind = icrc_pkg::LS_SKIP;
		endcase
	end

	wire icrc_pkg::icrc_lstate_t nxt_lstate = lk_frame_start ? icrc_pkg::LS_IDLE :
		(lk_first ? (lk_match ? nxt_kind : icrc_pkg::LS_SKIP) : lstate_ff);
	wire [2:0] nxt_idx = lk_frame_start ? 3'h0 :
		((lk_byte_valid && idx_ff != 3'h7) ? idx_ff + 3'h1 : idx_ff);
	wire nxt_addressed = lk_frame_start ? 1'b0 : (lk_first ? lk_match : lk_addressed_ff);

	// Erase and blank dummy bytes still advance the address but never fold
	assign crc_io.seed = is_clr;
	assign crc_io.fold = datw_data && is_prog;
	assign crc_io.data = lk_byte;

	wire [6:0] nxt_low = datw_low ? lk_byte[6:0] :
		((datw_data || datr_data) ? low_ff + 7'h01 : low_ff);
	wire [7:0] nxt_cmd  = cmdw_cmd ? lk_byte : cmd_ff;
	wire [7:0] nxt_page = cmdw_page ? lk_byte : page_ff;

	// Byte to send for the following index of a command read
	wire [7:0] tx_sel = (idx_ff == 3'h0) ? cmd_ff :
		(idx_ff == 3'h1) ? page_ff :
		(idx_ff == 3'h2) ? {1'b0, low_ff} :
		(idx_ff == 3'h3) ? crc_io.crc[15:8] :
		(idx_ff == 3'h4) ? crc_io.crc[7:0] : 8'h00;
	wire [7:0] nxt_tx = lk_byte_valid ? tx_sel : lk_tx_byte_ff;

	always_ff @(posedge lclk or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			lstate_ff       <= icrc_pkg::LS_IDLE;
			idx_ff          <= 3'h0;
			lk_addressed_ff <= 1'b0;
		end else begin
			lstate_ff       <= nxt_lstate;
			idx_ff          <= nxt_idx;
			lk_addressed_ff <= nxt_addressed;
		end
	end

	always_ff @(posedge lclk or negedge lrst_n_ff) begin
		if (!lrst_n_ff) begin
			cmd_ff         <= 8'h00;
			page_ff        <= 8'h00;
			low_ff         <= 7'h00;
			lk_tx_byte_ff  <= 8'h00;
			lk_wake_tgl_ff <= 1'b0;
		end else begin
			cmd_ff         <= nxt_cmd;
			page_ff        <= nxt_page;
			low_ff         <= nxt_low;
			lk_tx_byte_ff  <= nxt_tx;
			lk_wake_tgl_ff <= lk_wake_tgl_ff ^ is_rst;
		end
	end

	assign lk_addressed = lk_addressed_ff;
	assign lk_tx_byte   = lk_tx_byte_ff;

	icrc_crc16 u_crc (
		.lclk   (lclk),
		.lrst_n (lrst_n_ff),
		.crc_io (crc_io.eng)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	unlock_key_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_unlock && key_ok |=> isp_mode_ff)
		else $error("unlock key did not enable programming");

	unlock_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_unlock && !key_ok |=> !isp_mode_ff)
		else $error("wrong unlock value enabled programming");

	wake_leave_a: assert property (@(posedge pclk) disable iff (!presetn)
		wake_edge && !wr_unlock |=> !isp_mode_ff && cpu_wake_ff ##1 !cpu_wake_ff)
		else $error("restart did not leave programming mode with one wake pulse");

	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_access && !pready_ff |=> pready_ff ##1 !pready_ff)
		else $error("register access not answered in one cycle");

	clr_cmd_a: assert property (@(posedge lclk) disable iff (!lrst_n_ff)
		is_clr |=> crc_io.crc == 16'hFFFF)
		else $error("clear command did not seed checksum");

	nack_hold_a: assert property (@(posedge lclk) disable iff (!lrst_n_ff)
		in_datw && idx_ff >= 3'h2 && !lk_slave_ack
		|=> $stable(crc_io.crc) && $stable(low_ff))
		else $error("refused data byte changed checksum or address");

	low_skip_a: assert property (@(posedge lclk) disable iff (!lrst_n_ff)
		datw_low || (datw_data && !is_prog) |=> $stable(crc_io.crc))
		else $error("address or erase dummy byte folded");

	prog_count_a: assert property (@(posedge lclk) disable iff (!lrst_n_ff)
		datw_data && !lk_frame_start |=> low_ff == $past(low_ff) + 7'h01)
		else $error("acknowledged data byte did not advance address");

	crc_readout_a: assert property (@(posedge lclk) disable iff (!lrst_n_ff)
		in_cmdr && idx_ff == 3'h3 |=> lk_tx_byte_ff == crc_io.crc[15:8])
		else $error("checksum high byte not presented");

	clr_seen_c: cover property (@(posedge lclk) disable iff (!lrst_n_ff) is_clr);
	read_crc_c: cover property (@(posedge lclk) disable iff (!lrst_n_ff)
		in_cmdr && idx_ff == 3'h4);
	wake_seen_c: cover property (@(posedge pclk) disable iff (!presetn) cpu_wake_ff);

endmodule

`default_nettype wire

// ==== verification/icrc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icrc_consts.svh"

module icrc_host_model #(
	parameter logic [7:0] TGT = 8'hA4
) (
	// Link clock
	input  wire logic       lclk,
	// Byte stream into the block
	output logic            lk_frame_start,
	output logic            lk_byte_valid,
	output logic      [7:0] lk_byte,
	output logic            lk_slave_ack,
	// Answer from the block
	input  wire logic [7:0] lk_tx_byte
);
	initial begin
		lk_frame_start = 1'b0;
		lk_byte_valid  = 1'b0;
		lk_byte        = 8'h00;
		lk_slave_ack   = 1'b0;
	end

	// Released lines show the inverse, so a stale copy never passes
	task automatic send_byte(input logic [7:0] b, input logic ack);
		@(posedge lclk);
		lk_byte_valid <= 1'b1;
		lk_byte       <= b;
		lk_slave_ack  <= ack;
		@(posedge lclk);
		lk_byte_valid <= 1'b0;
		lk_byte       <= ~b;
		lk_slave_ack  <= ~ack;
	endtask

	task automatic start_frame(input logic [1:0] kind);
		@(posedge lclk);
		lk_frame_start <= 1'b1;
		@(posedge lclk);
		lk_frame_start <= 1'b0;
		send_byte({TGT[7:2], kind}, 1'b1);
	endtask

	task automatic command(input logic [7:0] cmd, input logic [7:0] page);
		start_frame(`ICRC_KIND_CMDW);
		send_byte(cmd, 1'b1);
		send_byte(page, 1'b1);
	endtask

	// Checksum comes back as fifth and sixth byte of a command read
	task automatic read_crc(output logic [15:0] crc);
		start_frame(`ICRC_KIND_CMDR);
		repeat (3) send_byte(8'h00, 1'b1);
		@(posedge lclk);
		#1 crc[15:8] = lk_tx_byte;
		send_byte(8'h00, 1'b1);
		@(posedge lclk);
		#1 crc[7:0] = lk_tx_byte;
	endtask
endmodule

`default_nettype wire

// ==== verification/icrc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "icrc_consts.svh"

module icrc_top_tb_top;
	localparam logic [7:0] TGT    = 8'hA4;
	localparam logic [7:0] A_TGT  = `ICRC_ADDR_TARGET;
	localparam logic [7:0] A_UNL  = `ICRC_ADDR_UNLOCK;
	localparam logic [7:0] A_STAT = `ICRC_ADDR_STATUS;
	logic        pclk, presetn, psel, penable, pwrite, lclk;
	logic [7:0]  paddr, lk_byte, lk_tx_byte;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, isp_mode, cpu_wake, lk_addressed;
	logic        lk_frame_start, lk_byte_valid, lk_slave_ack, er, wake_seen;
	logic [15:0] crc;
	int          err_total, cmp_count, n;

	// ----------------------------------------
	// Clocks, design and far side
	// ----------------------------------------
	initial pclk = 1'b0;
	initial lclk = 1'b0;
	always #50 pclk = ~pclk;
	always #7.5 lclk = ~lclk;

	icrc_top icrc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .isp_mode(isp_mode), .cpu_wake(cpu_wake),
		.lclk(lclk), .lk_frame_start(lk_frame_start), .lk_byte_valid(lk_byte_valid),
		.lk_byte(lk_byte), .lk_slave_ack(lk_slave_ack), .lk_addressed(lk_addressed),
		.lk_tx_byte(lk_tx_byte));

	icrc_host_model #(.TGT(TGT)) icrc_host_model_inst (.lclk(lclk),
		.lk_frame_start(lk_frame_start), .lk_byte_valid(lk_byte_valid),
		.lk_byte(lk_byte), .lk_slave_ack(lk_slave_ack), .lk_tx_byte(lk_tx_byte));

	// Wake is a single pulse, so latch it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_seen <= 1'b0;
		end else if (cpu_wake === 1'b1) begin
			wake_seen <= 1'b1;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
			k++;
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		check("pready_wait", k, 32'h0000_0001);
	endtask

	// ----------------------------------------
	// Watchdog, a run takes well under 100 us
	// ----------------------------------------
	initial begin
		#1_000_000;
		err_total++;
		$display("watchdog expired");
		print_verdict();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		err_total = 0;
		cmp_count = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(A_STAT[7:0], 1'b0, 32'h0000_0000);
		check("status_rst", rd, 32'h0000_0000);
		apb(8'h00, 1'b0, 32'h0000_0000);
		check("unmapped_err", {31'h0, er}, 32'h0000_0001);
		apb(A_TGT[7:0], 1'b1, {24'h0, TGT});
		apb(A_TGT[7:0], 1'b0, 32'h0000_0000);
		check("target_wo", rd, 32'h0000_0000);
		apb(A_UNL[7:0], 1'b1, 32'h0000_0055);
		apb(A_STAT[7:0], 1'b0, 32'h0000_0000);
		check("bad_key", rd, 32'h0000_0000);
		apb(A_UNL[7:0], 1'b1, {24'h0, `ICRC_UNLOCK_KEY});
		apb(A_STAT[7:0], 1'b0, 32'h0000_0000);
		check("good_key", rd, 32'h0000_0001);
		check("isp_mode_on", {31'h0, isp_mode}, 32'h0000_0001);
		apb(A_UNL[7:0], 1'b0, 32'h0000_0000);
		check("unlock_wo", rd, 32'h0000_0000);
		$display("test registers done");

		icrc_host_model_inst.read_crc(crc);
		check("crc_seed", {16'h0, crc}, 32'h0000_FFFF);
		check("addressed", {31'h0, lk_addressed}, 32'h0000_0001);
		icrc_host_model_inst.command(8'hA0, 8'h00);
		icrc_host_model_inst.start_frame(`ICRC_KIND_DATW);
		icrc_host_model_inst.send_byte(8'h00, 1'b1);
		icrc_host_model_inst.send_byte(8'hF6, 1'b1);
		icrc_host_model_inst.send_byte(8'h5A, 1'b0);
		icrc_host_model_inst.send_byte(8'h28, 1'b1);
		icrc_host_model_inst.send_byte(8'hC3, 1'b1);
		icrc_host_model_inst.read_crc(crc);
		check("crc_prog", {16'h0, crc}, 32'h0000_7031);
		icrc_host_model_inst.read_crc(crc);
		check("crc_reread", {16'h0, crc}, 32'h0000_7031);
		$display("test program done");

		icrc_host_model_inst.command(8'hD7, 8'h00);
		icrc_host_model_inst.read_crc(crc);
		check("crc_clear", {16'h0, crc}, 32'h0000_FFFF);
		for (int i = 0; i < 2; i++) begin
			icrc_host_model_inst.command(i == 0 ? 8'h30 : 8'h68, 8'h01);
			icrc_host_model_inst.start_frame(`ICRC_KIND_DATW);
			icrc_host_model_inst.send_byte(8'h00, 1'b1);
			icrc_host_model_inst.send_byte(8'hF6, 1'b1);
			icrc_host_model_inst.read_crc(crc);
			check("crc_erase", {16'h0, crc}, 32'h0000_FFFF);
		end
		$display("test clear and erase done");

		icrc_host_model_inst.command(8'h48, 8'h00);
		n = 0;
		while (isp_mode !== 1'b0 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		check("isp_mode_off", {31'h0, isp_mode}, 32'h0000_0000);
		check("cpu_wake", {31'h0, wake_seen}, 32'h0000_0001);
		icrc_host_model_inst.read_crc(crc);
		check("not_addressed", {31'h0, lk_addressed}, 32'h0000_0000);
		$display("test restart done");
		print_verdict();
	end
endmodule

`default_nettype wire
